// File: rtl/adc_cfg_consts.svh
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH
`define ADDR_OUT_TIMING   8'h62
`define ADDR_POWER_FMT    8'h63
`define ADDR_TEST_PAT     8'h65
`define ADDR_GAIN         8'h68
`define ADDR_PAT_LOW      8'h69
`define ADDR_PAT_HIGH     8'h6A
`define ADDR_INPUT_CLOCK_BUFFER_GAIN   8'h6B
`define ADDR_IF_RESET     8'h6C
`define ADDR_PSCALE_REF   8'h6D
`define ADDR_TERM_DRIVE   8'h7E
`define ADDR_CURR_DOUBLE  8'h7F
`define ADDR_HOLE         8'h64
`define SOFT_RESET_BIT    1
`define CLK_POS_DEFAULT   5'h01
`define REG_DEFAULT       8'h00
`define FRAME_LAST        4'hF
`define STABLE_TIME_US    6500
`define CLK_MHZ           50
`endif

// File: rtl/adc_cfg_pkg.sv
package adc_cfg_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {ST_WAIT, ST_READY} startup_e;
endpackage

// File: rtl/adc_serial_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_consts.svh"
// Notes on behaviour
// R1 - Controller resets registers after power-up
// R2 - Soft reset bit restores defaults, self-clears
// R3 - Reset pin low during soft reset use
// R4 - Wait 5 ms before hardware reset; the testbench asserts reset at time zero
// R5 - Hardware reset pulse at least 10 ns
// R6 - Wait 25 ns before select active
// R7 - Outputs stable about 6.5 ms after power
// R8 - Strap mode holds reset pin high
// R9 - 0x62 holds data and clock position
// R10 - 0x7E holds termination and drive fields
// R11 - Shift on falling clock while select low
// R12 - Address then data, write each 16th edge
// R13 - Controller writes unused bits as zero
// R14 - Unknown addresses change nothing
// R15 - Soft reset bit reads back zero
module adc_serial_config_regs
(
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                serialClk,
    input  wire logic                serialSelectN,
    input  wire logic                serialDataIn,
    output var  adc_cfg_pkg::byte_t  outputTiming,
    output var  adc_cfg_pkg::byte_t  powerFormat,
    output var  adc_cfg_pkg::byte_t  testPattern,
    output var  adc_cfg_pkg::byte_t  gainControl,
    output var  adc_cfg_pkg::byte_t  patternLow,
    output var  adc_cfg_pkg::byte_t  patternHigh,
    output var  adc_cfg_pkg::byte_t  clkinGain,
    output var  adc_cfg_pkg::byte_t  interfaceReset,
    output var  adc_cfg_pkg::byte_t  powerScaleRef,
    output var  adc_cfg_pkg::byte_t  termDrive,
    output var  adc_cfg_pkg::byte_t  currDouble,
    output var  logic                outputsStable
);
    import adc_cfg_pkg::*;

    localparam int STABLE_CYCLES = `STABLE_TIME_US * `CLK_MHZ;
    localparam logic [18:0] STABLE_LAST = 19'(STABLE_CYCLES - 1);

    frame_if frame ();

    serial_shifter shifter
    (
        .serialClk     (serialClk),
        .reset         (reset),
        .serialSelectN (serialSelectN),
        .serialDataIn  (serialDataIn),
        .frame         (frame)
    );

    // Toggle crossing: two flops, then an edge on the settled copies
    logic [2:0] togSync_q;
    logic       wordValid;
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            togSync_q <= 3'b000;
        else
            togSync_q <= {togSync_q[1:0], frame.toggle};
    end
    assign wordValid = togSync_q[2] ^ togSync_q[1];

    // Address and data are stable long before the toggle settles
    byte_t wAddr;
    byte_t wData;
    assign wAddr = frame.addr;
    assign wData = frame.data;

    logic softReset;
    assign softReset = wordValid && wAddr == `ADDR_IF_RESET && wData[`SOFT_RESET_BIT];

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            outputTiming   <= {3'b000, `CLK_POS_DEFAULT}; // R9
            powerFormat    <= `REG_DEFAULT;
            testPattern    <= `REG_DEFAULT;
            gainControl    <= `REG_DEFAULT;
            patternLow     <= `REG_DEFAULT;
            patternHigh    <= `REG_DEFAULT;
            clkinGain      <= `REG_DEFAULT;
            interfaceReset <= `REG_DEFAULT;
            powerScaleRef  <= `REG_DEFAULT;
            termDrive      <= `REG_DEFAULT;
            currDouble     <= `REG_DEFAULT;
        end
        // A soft reset word restores every default, clearing its own bit too
        else if (softReset) // R2
        begin
            outputTiming   <= {3'b000, `CLK_POS_DEFAULT}; // R9
            powerFormat    <= `REG_DEFAULT;
            testPattern    <= `REG_DEFAULT;
            gainControl    <= `REG_DEFAULT;
            patternLow     <= `REG_DEFAULT;
            patternHigh    <= `REG_DEFAULT;
            clkinGain      <= `REG_DEFAULT;
            interfaceReset <= `REG_DEFAULT; // R15
            powerScaleRef  <= `REG_DEFAULT;
            termDrive      <= `REG_DEFAULT;
            currDouble     <= `REG_DEFAULT;
        end
        else if (wordValid)
        begin
            case (wAddr) // R14
                `ADDR_OUT_TIMING:  outputTiming   <= wData; // R9
                `ADDR_POWER_FMT:   powerFormat    <= wData;
                `ADDR_TEST_PAT:    testPattern    <= wData;
                `ADDR_GAIN:        gainControl    <= wData;
                `ADDR_PAT_LOW:     patternLow     <= wData;
                `ADDR_PAT_HIGH:    patternHigh    <= wData;
                `ADDR_INPUT_CLOCK_BUFFER_GAIN:  clkinGain      <= wData;
                `ADDR_IF_RESET:    interfaceReset <= wData;
                `ADDR_PSCALE_REF:  powerScaleRef  <= wData;
                `ADDR_TERM_DRIVE:  termDrive      <= wData; // R10
                `ADDR_CURR_DOUBLE: currDouble     <= wData;
                default:           ;
            endcase
        end
    end

    // Output stable flag after the power-up delay
    startup_e    state_q;
    logic [18:0] stableCnt_q;
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q       <= ST_WAIT;
            stableCnt_q   <= 19'h0_0000;
            outputsStable <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_WAIT:
                begin
                    stableCnt_q <= stableCnt_q + 19'h0_0001;
                    if (stableCnt_q == STABLE_LAST) // R7
                    begin
                        state_q       <= ST_READY;
                        outputsStable <= 1'b1;
                    end
                end
                ST_READY: outputsStable <= 1'b1;
                default:  state_q <= ST_WAIT;
            endcase
        end
    end

    a_soft_clears: assert property (@(posedge ref_clk) disable iff (reset) // R15
        softReset |=> (interfaceReset == `REG_DEFAULT && outputTiming == {3'b000, `CLK_POS_DEFAULT}))
        else $error("Soft reset did not restore defaults");
    a_rst_bit_zero: assert property (@(posedge ref_clk) disable iff (reset) // R2
        !interfaceReset[`SOFT_RESET_BIT])
        else $error("Soft reset bit reads one");
    a_write_lands: assert property (@(posedge ref_clk) disable iff (reset) // R9
        (wordValid && wAddr == `ADDR_OUT_TIMING) |=> outputTiming == $past(wData))
        else $error("Position register not written");
    a_term_lands: assert property (@(posedge ref_clk) disable iff (reset) // R10
        (wordValid && wAddr == `ADDR_TERM_DRIVE) |=> termDrive == $past(wData))
        else $error("Termination register not written");
    // Each mapped address lands in its own register, except a 0x6C word with the soft reset bit set
    a_fmt_lands: assert property (@(posedge ref_clk) disable iff (reset) // R12
        (wordValid && wAddr == `ADDR_POWER_FMT) |=> powerFormat == $past(wData))
        else $error("Format register not written");
    a_pat_lands: assert property (@(posedge ref_clk) disable iff (reset) // R12
        (wordValid && wAddr == `ADDR_TEST_PAT) |=> testPattern == $past(wData))
        else $error("Pattern select register not written");
    a_gain_lands: assert property (@(posedge ref_clk) disable iff (reset) // R12
        (wordValid && wAddr == `ADDR_GAIN) |=> gainControl == $past(wData))
        else $error("Gain register not written");
    a_low_lands: assert property (@(posedge ref_clk) disable iff (reset) // R12
        (wordValid && wAddr == `ADDR_PAT_LOW) |=> patternLow == $past(wData))
        else $error("Pattern low register not written");
    a_high_lands: assert property (@(posedge ref_clk) disable iff (reset) // R12
        (wordValid && wAddr == `ADDR_PAT_HIGH) |=> patternHigh == $past(wData))
        else $error("Pattern high register not written");
    a_clkin_lands: assert property (@(posedge ref_clk) disable iff (reset) // R12
        (wordValid && wAddr == `ADDR_INPUT_CLOCK_BUFFER_GAIN) |=> clkinGain == $past(wData))
        else $error("Clock gain register not written");
    a_iface_lands: assert property (@(posedge ref_clk) disable iff (reset) // R12
        (wordValid && wAddr == `ADDR_IF_RESET && !softReset) |=> interfaceReset == $past(wData))
        else $error("Interface register not written");
    a_scale_lands: assert property (@(posedge ref_clk) disable iff (reset) // R12
        (wordValid && wAddr == `ADDR_PSCALE_REF) |=> powerScaleRef == $past(wData))
        else $error("Scaling register not written");
    a_curr_lands: assert property (@(posedge ref_clk) disable iff (reset) // R12
        (wordValid && wAddr == `ADDR_CURR_DOUBLE) |=> currDouble == $past(wData))
        else $error("Current register not written");
    a_soft_others: assert property (@(posedge ref_clk) disable iff (reset) // R2
        softReset |=> (powerFormat == `REG_DEFAULT && testPattern == `REG_DEFAULT && gainControl == `REG_DEFAULT
            && patternLow == `REG_DEFAULT && patternHigh == `REG_DEFAULT && clkinGain == `REG_DEFAULT
            && powerScaleRef == `REG_DEFAULT && termDrive == `REG_DEFAULT && currDouble == `REG_DEFAULT))
        else $error("Soft reset left a register set");
    a_bad_addr: assert property (@(posedge ref_clk) disable iff (reset) // R14
        (wordValid && wAddr == `ADDR_HOLE) |=> $stable(gainControl) && $stable(termDrive))
        else $error("Unmapped write changed state");
    // Power-up count advances every cycle while waiting
    a_stable_late: assert property (@(posedge ref_clk) disable iff (reset) // R7
        $rose(outputsStable) |-> $past(stableCnt_q) == STABLE_LAST)
        else $error("Outputs flagged stable early");
    a_count_runs: assert property (@(posedge ref_clk) disable iff (reset) // R7
        (state_q == ST_WAIT && !$past(reset)) |=> stableCnt_q == $past(stableCnt_q) + 19'h0_0001)
        else $error("Power-up count stalled");
    a_word_pulse: assert property (@(posedge ref_clk) disable iff (reset) // R12
        wordValid |=> !wordValid)
        else $error("Word valid longer than a cycle");
    a_no_write_idle: assert property (@(posedge ref_clk) disable iff (reset) // R12
        !wordValid && !softReset |=> $stable(powerFormat))
        else $error("Register changed without a word");
    c_soft_reset: cover property (@(posedge ref_clk) softReset);
    c_write_gain: cover property (@(posedge ref_clk) wordValid && wAddr == `ADDR_GAIN);
    c_ready: cover property (@(posedge ref_clk) $rose(outputsStable));
endmodule
`default_nettype wire

// File: rtl/frame_if.sv
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
    logic       toggle;
    logic [7:0] addr;
    logic [7:0] data;
    modport shifter (output toggle, output addr, output data);
    modport bank    (input toggle, input addr, input data);
endinterface
`default_nettype wire

// File: rtl/serial_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_consts.svh"
module serial_shifter
(
    input  wire logic   serialClk,
    input  wire logic   reset,
    input  wire logic   serialSelectN,
    input  wire logic   serialDataIn,
    frame_if.shifter    frame
);
    logic [3:0]  bitCnt_q;
    logic [14:0] shift_q;
    logic        toggle_q;
    logic [7:0]  addr_q;
    logic [7:0]  data_q;

    // Count restarts while select is high; partial frames are dropped
    always_ff @(negedge serialClk or posedge serialSelectN)
    begin
        if (serialSelectN)
            bitCnt_q <= 4'h0;
        else
            bitCnt_q <= bitCnt_q + 4'h1; // R11
    end

    always_ff @(negedge serialClk)
    begin
        if (!serialSelectN)
            shift_q <= {shift_q[13:0], serialDataIn}; // R11
    end

    // Every 16th falling edge delivers one word, address first
    // Reset clears the toggle so no stale word crosses after release
    always_ff @(negedge serialClk or posedge reset)
    begin
        if (reset)
        begin
            addr_q   <= `REG_DEFAULT;
            data_q   <= `REG_DEFAULT;
            toggle_q <= 1'b0;
        end
        else if (!serialSelectN && bitCnt_q == `FRAME_LAST)
        begin
            addr_q   <= shift_q[14:7]; // R12
            data_q   <= {shift_q[6:0], serialDataIn}; // R12
            toggle_q <= ~toggle_q;
        end
    end

    assign frame.toggle = toggle_q;
    assign frame.addr   = addr_q;
    assign frame.data   = data_q;

    a_frame_count: assert property (@(negedge serialClk) disable iff (serialSelectN || reset) // R12
        (bitCnt_q == `FRAME_LAST) |=> (toggle_q != $past(toggle_q)))
        else $error("Frame not loaded at sixteenth edge");
    c_frame_done: cover property (@(negedge serialClk) !serialSelectN && bitCnt_q == `FRAME_LAST);
endmodule
`default_nettype wire

// File: testbench/serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host
(
    output var logic serialClk,
    output var logic serialSelectN,
    output var logic serialDataIn
);
    // Clock idles high and only runs inside a frame
    initial
    begin
        serialClk     <= 1'b1;
        serialSelectN <= 1'b1;
        serialDataIn  <= 1'b0;
    end

    // Data changes at the rising edge, the device samples at the falling one
    task automatic sendBit(input logic b);
        serialDataIn = b;
        #15 serialClk = 1'b0;
        #15 serialClk = 1'b1;
    endtask

    // Sends up to two words, then extra bits that do not fill a word
    task automatic sendFrame(input logic [15:0] w0, input logic [15:0] w1, input int words, input int extra);
        logic [31:0] s;
        s = {w0, w1};
        #25 serialSelectN = 1'b0;
        #25;
        for (int i = 0; i < 16 * words + extra; i++)
            sendBit(i < 32 ? s[31 - i] : ~serialDataIn);
        #25 serialSelectN = 1'b1;
        serialDataIn = ~serialDataIn;
    endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_consts.svh"
module tb;
    import adc_cfg_pkg::*;
    logic      ref_clk = 1'b0;
    logic      reset;
    wire logic serialClk;
    wire logic serialSelectN;
    wire logic serialDataIn;
    logic      outputsStable;
    byte_t     regs [11];
    byte_t     expv [11];
    int        n_errors = 0;
    int        checked  = 0;
    const byte_t addrs [11] = '{`ADDR_OUT_TIMING, `ADDR_POWER_FMT, `ADDR_TEST_PAT, `ADDR_GAIN, `ADDR_PAT_LOW,
        `ADDR_PAT_HIGH, `ADDR_INPUT_CLOCK_BUFFER_GAIN, `ADDR_IF_RESET, `ADDR_PSCALE_REF, `ADDR_TERM_DRIVE, `ADDR_CURR_DOUBLE};
    // Unused bits are kept zero
    const byte_t masks [11] = '{8'h7F, 8'h98, 8'hE0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h18, 8'hFF, 8'hFF, 8'hFF};
    // Addresses outside the map, near it and far from it
    const byte_t holes [8] = '{8'h61, 8'h64, 8'h66, 8'h67, 8'h6E, 8'h7D, 8'h80, 8'hFF};

    function automatic bit isMapped(input byte_t a);
        foreach (addrs[i])
            if (addrs[i] == a)
                return 1'b1;
        return 1'b0;
    endfunction

    always #10 ref_clk = ~ref_clk;

    serial_host host (.serialClk(serialClk), .serialSelectN(serialSelectN), .serialDataIn(serialDataIn));

    adc_serial_config_regs dut (.ref_clk(ref_clk), .reset(reset), .serialClk(serialClk),
        .serialSelectN(serialSelectN), .serialDataIn(serialDataIn), .outputTiming(regs[0]),
        .powerFormat(regs[1]), .testPattern(regs[2]), .gainControl(regs[3]), .patternLow(regs[4]),
        .patternHigh(regs[5]), .clkinGain(regs[6]), .interfaceReset(regs[7]), .powerScaleRef(regs[8]),
        .termDrive(regs[9]), .currDouble(regs[10]), .outputsStable(outputsStable));

    function automatic byte_t defaultOf(input int i);
        return (i == 0) ? {3'b000, `CLK_POS_DEFAULT} : `REG_DEFAULT;
    endfunction

    task automatic setDefaults();
        for (int i = 0; i < 11; i++)
            expv[i] = defaultOf(i);
    endtask

    task automatic check(input byte_t seen, input byte_t want);
        checked++;
        if (seen !== want)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic checkAll();
        for (int i = 0; i < 11; i++)
            check(regs[i], expv[i]);
    endtask

    task automatic writeReg(input byte_t a, input byte_t d);
        host.sendFrame({a, d}, 16'h0000, 1, 0);
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #1ms;
        n_errors++;
        complete_run();
    end

    initial
    begin
        byte_t d;
        byte_t a;
        int    k;
        reset <= 1'b1;
        k = $urandom(10);
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        setDefaults();
        checkAll();
        check({7'h00, outputsStable}, 8'h00);
        for (int r = 0; r < 3; r++)
            for (int i = 0; i < 11; i++)
            begin
                d = byte_t'($urandom) & masks[i];
                writeReg(addrs[i], d);
                expv[i] = d;
                checkAll();
            end
        host.sendFrame({`ADDR_GAIN, 8'h5A}, {`ADDR_PAT_LOW, 8'hA5}, 2, 5);
        host.sendFrame({`ADDR_GAIN, 8'h00}, 16'h0000, 0, 9);
        repeat (6) @(posedge ref_clk);
        expv[3] = 8'h5A;
        expv[4] = 8'hA5;
        checkAll();
        for (int i = 0; i < 16; i++)
        begin
            a = byte_t'($urandom);
            if (i < 8)
                a = holes[i];
            if (isMapped(a))
                a = a ^ 8'h80;
            writeReg(a, byte_t'($urandom));
            checkAll();
        end
        writeReg(8'h00, 8'hFF);
        checkAll();
        writeReg(`ADDR_IF_RESET, 8'h1A);
        setDefaults();
        checkAll();
        writeReg(`ADDR_TEST_PAT, 8'hA0);
        expv[2] = 8'hA0;
        checkAll();
        @(posedge ref_clk);
        reset <= 1'b1;
        host.sendFrame({`ADDR_GAIN, 8'h33}, 16'h0000, 1, 0);
        repeat (8) @(posedge ref_clk);
        setDefaults();
        checkAll();
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        checkAll();
        check({7'h00, outputsStable}, 8'h00);
        writeReg(`ADDR_GAIN, 8'h3C);
        expv[3] = 8'h3C;
        checkAll();
        complete_run();
    end
endmodule
`default_nettype wire
